// File: sgc_consts.vh
`ifndef SGC_CONSTS_VH
`define SGC_CONSTS_VH
// Register byte offsets
`define SGC_REG_GROUP_CTRL 12'h000
`define SGC_REG_GROUP_STAT 12'h004
`define SGC_REG_SYNC_CTRL 12'h008
`define SGC_REG_SYNC_LIMIT 12'h00c
`define SGC_REG_DEAD_LIVE 12'h010
`define SGC_REG_MEAS_IN 12'h014
`define SGC_REG_MC_CTRL 12'h018
`define SGC_REG_MC_RAISE 12'h01c
`define SGC_REG_MC_STAT 12'h020
`define SGC_REG_EVENT 12'h024
// Field positions
`define SGC_ACT_SEL_LSB 0
`define SGC_EDIT_SEL_LSB 4
`define SGC_HOLD_PU_EN_BIT 8
`define SGC_HOLD_OPEN_EN_BIT 9
`define SGC_PU_MASK_LSB 16
`define SGC_SYNC_EN_BIT 0
`define SGC_DSP_LSB 4
`define SGC_MC_EN_BIT 0
`define SGC_MC_BLK_LSB 4
`define SGC_MC_RELAY_LSB 12
`define SGC_MC_GRP_LSB 17
`define SGC_MC_TIME_LSB 22
// Reset values and limits
`define SGC_GROUP_CTRL_RST 32'h0000_0000
`define SGC_MC_TIME_RST 10'h005
`define SGC_MC_TIME_MIN 10'h001
`define SGC_MC_TIME_MAX 10'h3e8
`define SGC_RAISE_MAX 7'h64
// Line frequency report threshold, centivolts of terminal voltage
`define SGC_FREQ_VMIN_CV 16'h03e8
// Timebase: one second of 50 ns cycles
`define SGC_CLK_HZ 20000000
`define SGC_SEC_NS 1000000000
`define SGC_CLK_NS 50
// Dead source permissive codes
`define SGC_DSP_OFF 3'h0
`define SGC_DSP_BOTH_DEENERGIZED 3'h1
`define SGC_DSP_LINE_UP_BUS_DOWN 3'h2
`define SGC_DSP_LINE_DOWN_BUS_UP 3'h3
`define SGC_DSP_EITHER_DEENERGIZED 3'h4
`define SGC_DSP_EXACTLY_ONE_DEENERGIZED 3'h5
`endif

// File: sgc_top.v
`timescale 1ns/1ps
`include "sgc_consts.vh"
module sgc_top #(
   parameter [31:0] SEC_CYCLES = `SGC_SEC_NS / `SGC_CLK_NS
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire [3:1] group_req_in,
   input wire [7:0] element_pickup,
   input wire breaker_open,
   input wire manual_close_req,
   input wire reclose_req,
   input wire [15:0] bus_mag,
   input wire [15:0] line_mag,
   input wire [15:0] mag_delta,
   input wire [15:0] phase_delta,
   input wire [15:0] frequency_delta,
   input wire [15:0] line_terminal_cv,
   input wire [15:0] line_freq,
   output reg [1:0] active_group,
   output reg [3:0] group_led,
   output reg close_out,
   output reg [15:0] line_freq_report,
   output reg [4:0] ioc_block,
   output reg [34:0] toc_raise,
   output reg [4:0] aux_relay,
   output reg [1:0] mc_group,
   output reg event_pulse
);
   // Control registers and internal state
   reg [31:0] group_ctrl_q;
   reg [31:0] sync_ctrl_q;
   reg [31:0] sync_limit_q;
   reg [31:0] dead_live_q;
   reg [31:0] mc_ctrl_q;
   reg [31:0] mc_raise_q;
   reg [15:0] event_cnt_q;
   reg [2:0] last_event_q;
   reg [1:0] act_q;
   reg [23:0] flash_q;
   reg [31:0] sec_cnt_q;
   reg [9:0] win_q;
   reg mc_d1_q;
   wire wr_en;
   wire rd_en;
   wire sec_tick;
   wire [1:0] req_grp;
   wire hold_grp;
   wire bus_dead;
   wire bus_live;
   wire line_dead;
   wire line_live;
   wire deltas_ok;
   reg dsp_ok;
   wire sync_ok;
   wire mc_win;
   wire mc_start;
   wire [9:0] time_set;
   reg [31:0] rd_mux;
   integer i;

   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & ~penable & ~pwrite;

   // Highest requested group, setting included; 0 means group 1
   function [1:0] sgc_highest;
      input [1:0] setting;
      input [3:1] req;
      reg [1:0] r;
      begin
         r = setting;
         if (req[1] && r < 2'd1) begin
            r = 2'd1;
         end
         if (req[2] && r < 2'd2) begin
            r = 2'd2;
         end
         if (req[3]) begin
            r = 2'd3;
         end
         sgc_highest = r;
      end
   endfunction

   // Clamp block time into 1..1000 s
   function [9:0] sgc_clamp_time;
      input [9:0] t;
      begin
         if (t < `SGC_MC_TIME_MIN) begin
            sgc_clamp_time = `SGC_MC_TIME_MIN;
         end else if (t > `SGC_MC_TIME_MAX) begin
            sgc_clamp_time = `SGC_MC_TIME_MAX;
         end else begin
            sgc_clamp_time = t;
         end
      end
   endfunction

   // Clamp raise percentage to 100
   function [6:0] sgc_clamp_pct;
      input [7:0] p;
      begin
         if (p > {1'b0, `SGC_RAISE_MAX}) begin
            sgc_clamp_pct = `SGC_RAISE_MAX;
         end else begin
            sgc_clamp_pct = p[6:0];
         end
      end
   endfunction

   // Threshold byte to a fraction of nominal on the 16-bit scale
   function [15:0] sgc_scale_thr;
      input [7:0] t;
      begin
         sgc_scale_thr = {t, 8'h00};
      end
   endfunction

   // APB register writes
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         group_ctrl_q <= `SGC_GROUP_CTRL_RST;
         sync_ctrl_q <= 32'h0000_0000;
         sync_limit_q <= 32'h0000_0000;
         dead_live_q <= 32'h0000_0000;
         mc_ctrl_q <= {`SGC_MC_TIME_RST, 22'h000000};
         mc_raise_q <= 32'h0000_0000;
      end else if (wr_en) begin
         case (paddr)
            `SGC_REG_GROUP_CTRL: group_ctrl_q <= pwdata;
            `SGC_REG_SYNC_CTRL: sync_ctrl_q <= pwdata;
            `SGC_REG_SYNC_LIMIT: sync_limit_q <= pwdata;
            `SGC_REG_DEAD_LIVE: dead_live_q <= pwdata;
            `SGC_REG_MC_CTRL: mc_ctrl_q <= pwdata;
            `SGC_REG_MC_RAISE: mc_raise_q <= pwdata;
            default: begin
            end
         endcase
      end
   end

   // Group resolution
   assign req_grp = sgc_highest(group_ctrl_q[`SGC_ACT_SEL_LSB+1:`SGC_ACT_SEL_LSB],
                                group_req_in);
   // Masked pickups; caller marks only non-disabled elements as able to pick up
   assign hold_grp = (group_ctrl_q[`SGC_HOLD_PU_EN_BIT] &
                      |(element_pickup & group_ctrl_q[`SGC_PU_MASK_LSB+7:`SGC_PU_MASK_LSB]))
                     | (group_ctrl_q[`SGC_HOLD_OPEN_EN_BIT] & breaker_open);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_q <= 2'd0;
         event_cnt_q <= 16'h0000;
         last_event_q <= 3'h0;
         event_pulse <= 1'b0;
      end else begin
         event_pulse <= 1'b0;
         if (!hold_grp && req_grp != act_q) begin
            act_q <= req_grp;
            if (req_grp != 2'd0) begin
               event_pulse <= 1'b1;
               event_cnt_q <= event_cnt_q + 16'h0001;
               last_event_q <= {1'b1, req_grp};
            end
         end
      end
   end

   // Flash toggles on the seconds tick, slow enough to be seen
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_q <= 24'h000000;
      end else if (sec_tick) begin
         flash_q <= flash_q + 24'h000001;
      end
   end

   always @* begin
      group_led = 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
         if (active_group == i[1:0]) begin
            group_led[i] = 1'b1;
         end else if (group_ctrl_q[`SGC_EDIT_SEL_LSB+1:`SGC_EDIT_SEL_LSB] == i[1:0]) begin
            group_led[i] = flash_q[0];
         end
      end
   end

   // Synchrocheck and dead source decision
   assign bus_dead = bus_mag < sgc_scale_thr(dead_live_q[7:0]);
   assign line_dead = line_mag < sgc_scale_thr(dead_live_q[15:8]);
   assign bus_live = bus_mag > sgc_scale_thr(dead_live_q[23:16]);
   assign line_live = line_mag > sgc_scale_thr(dead_live_q[31:24]);
   assign deltas_ok = (mag_delta < sync_limit_q[15:0]) &
                      (phase_delta < {8'h00, sync_limit_q[23:16]}) &
                      (frequency_delta < {8'h00, sync_limit_q[31:24]});

   always @* begin
      case (sync_ctrl_q[`SGC_DSP_LSB+2:`SGC_DSP_LSB])
         `SGC_DSP_BOTH_DEENERGIZED: dsp_ok = bus_dead & line_dead;
         `SGC_DSP_LINE_UP_BUS_DOWN: dsp_ok = line_live & bus_dead;
         `SGC_DSP_LINE_DOWN_BUS_UP: dsp_ok = line_dead & bus_live;
         `SGC_DSP_EITHER_DEENERGIZED: dsp_ok = line_dead | bus_dead;
         `SGC_DSP_EXACTLY_ONE_DEENERGIZED: dsp_ok = (line_dead & bus_live) |
                                                    (bus_dead & line_live);
         default: dsp_ok = 1'b0;
      endcase
   end

   assign sync_ok = ~sync_ctrl_q[`SGC_SYNC_EN_BIT] | deltas_ok | dsp_ok;

   // Seconds divider for the block window
   assign sec_tick = (sec_cnt_q == SEC_CYCLES - 32'd1);
   assign time_set = sgc_clamp_time(mc_ctrl_q[`SGC_MC_TIME_LSB+9:`SGC_MC_TIME_LSB]);
   assign mc_start = manual_close_req & ~mc_d1_q & mc_ctrl_q[`SGC_MC_EN_BIT];
   assign mc_win = (win_q != 10'h000);

   // Restart aligns the second boundary with the close command
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sec_cnt_q <= 32'h0000_0000;
      end else if (mc_start || sec_tick) begin
         sec_cnt_q <= 32'h0000_0000;
      end else begin
         sec_cnt_q <= sec_cnt_q + 32'd1;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         win_q <= 10'h000;
         mc_d1_q <= 1'b0;
      end else begin
         mc_d1_q <= manual_close_req;
         if (mc_start) begin
            win_q <= time_set;
         end else if (sec_tick && mc_win) begin
            win_q <= win_q - 10'h001;
         end
      end
   end

   // Registered outputs; close_out and line_freq_report lag their inputs by one cycle, group and block outputs lag the request by two
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_group <= 2'd0;
      end else begin
         active_group <= act_q;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         close_out <= 1'b0;
      end else begin
         close_out <= (manual_close_req | reclose_req) & sync_ok;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_freq_report <= 16'h0000;
      end else begin
         line_freq_report <= (line_terminal_cv >= `SGC_FREQ_VMIN_CV) ?
                             line_freq : 16'h0000;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ioc_block <= 5'h00;
      end else begin
         ioc_block <= mc_win ? mc_ctrl_q[`SGC_MC_BLK_LSB+4:`SGC_MC_BLK_LSB]
                             : 5'h00;
      end
   end

   // Fields are six bits wide; the last one adds bits 31:30 and reaches 66 at most, so none can pass 100
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         toc_raise <= 35'h0;
      end else begin
         for (i = 0; i < 5; i = i + 1) begin
            toc_raise[i*7 +: 7] <= mc_win ? sgc_clamp_pct({1'b0, mc_raise_q[i*6 +: 6]} +
                                    ((i == 4) ? {6'h00, mc_raise_q[31:30]} : 8'h00))
                                           : 7'h00;
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         aux_relay <= 5'h00;
      end else begin
         aux_relay <= mc_win ? mc_ctrl_q[`SGC_MC_RELAY_LSB+4:`SGC_MC_RELAY_LSB]
                             : 5'h00;
      end
   end

   // Fixed group applies only while the window runs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mc_group <= 2'd0;
      end else if (!mc_win || !mc_ctrl_q[`SGC_MC_GRP_LSB+2]) begin
         mc_group <= act_q;
      end else begin
         mc_group <= mc_ctrl_q[`SGC_MC_GRP_LSB+1:`SGC_MC_GRP_LSB];
      end
   end

   // Read mux, registered in setup phase
   always @* begin
      case (paddr)
         `SGC_REG_GROUP_CTRL: rd_mux = group_ctrl_q;
         `SGC_REG_GROUP_STAT: rd_mux = {26'h0, group_ctrl_q[5:4], hold_grp, 1'b0, act_q};
         `SGC_REG_SYNC_CTRL: rd_mux = sync_ctrl_q;
         `SGC_REG_SYNC_LIMIT: rd_mux = sync_limit_q;
         `SGC_REG_DEAD_LIVE: rd_mux = dead_live_q;
         `SGC_REG_MEAS_IN: rd_mux = {26'h0, sync_ok, dsp_ok, deltas_ok, line_live,
                                     line_dead, bus_dead};
         `SGC_REG_MC_CTRL: rd_mux = mc_ctrl_q;
         `SGC_REG_MC_RAISE: rd_mux = mc_raise_q;
         `SGC_REG_MC_STAT: rd_mux = {21'h0, mc_win, win_q};
         `SGC_REG_EVENT: rd_mux = {13'h0, last_event_q, event_cnt_q};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_en) begin
         prdata <= rd_mux;
      end
   end
endmodule

// File: sgc_checker.sv
`timescale 1ns/1ps
module sgc_checker (
   input wire pclk,
   input wire presetn,
   input wire manual_close_req,
   input wire reclose_req,
   input wire [15:0] line_terminal_cv,
   input wire [15:0] line_freq,
   input wire [1:0] active_group,
   input wire [3:0] group_led,
   input wire close_out,
   input wire [15:0] line_freq_report,
   input wire [4:0] ioc_block,
   input wire [34:0] toc_raise,
   input wire event_pulse
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_rst_grp; $rose(presetn) |-> active_group == 2'h0; endproperty
   property p_led_on; group_led[active_group]; endproperty
   property p_led_cnt; $countones(group_led) <= 2; endproperty
   property p_close; close_out |-> $past(manual_close_req | reclose_req); endproperty
   property p_frq_lo;
      $past(presetn) && line_terminal_cv < 16'h03e8 |=> line_freq_report == 16'h0000;
   endproperty
   property p_frq_hi;
      $past(presetn) && line_terminal_cv >= 16'h03e8 |=> line_freq_report == $past(line_freq);
   endproperty
   property p_event;
      $past(presetn) && $changed(active_group) && active_group != 2'h0
         |-> (event_pulse || $past(event_pulse)) or (##[1:2] event_pulse);
   endproperty
   property p_raise;
      toc_raise[6:0] <= 7'h64 && toc_raise[13:7] <= 7'h64 && toc_raise[20:14] <= 7'h64
         && toc_raise[27:21] <= 7'h64 && toc_raise[34:28] <= 7'h64;
   endproperty
   property p_ioc;
      $rose(|ioc_block) |-> $past(manual_close_req) || $past(manual_close_req, 2)
         || $past(manual_close_req, 3);
   endproperty
   a_rst_grp: assert property (p_rst_grp) else $error("group not 1 after reset");
   a_led_on: assert property (p_led_on) else $error("active led off");
   a_led_cnt: assert property (p_led_cnt) else $error("too many leds");
   a_close: assert property (p_close) else $error("close without request");
   a_frq_lo: assert property (p_frq_lo) else $error("freq shown at low volts");
   a_frq_hi: assert property (p_frq_hi) else $error("freq not shown");
   a_event: assert property (p_event) else $error("group change not logged");
   a_raise: assert property (p_raise) else $error("raise above 100");
   a_ioc: assert property (p_ioc) else $error("block without close");
   c_close: cover property (close_out);
   c_event: cover property (event_pulse);
   c_ioc: cover property ($rose(|ioc_block));
endmodule

bind sgc_top sgc_checker chk_u (.pclk, .presetn, .manual_close_req, .reclose_req,
   .line_terminal_cv, .line_freq, .active_group, .group_led, .close_out, .line_freq_report,
   .ioc_block, .toc_raise, .event_pulse);

// File: sgc_field.sv
`timescale 1ns/1ps
module sgc_field (
   input wire pclk,
   input wire close_out,
   output logic [3:1] group_req_in,
   output logic [7:0] element_pickup,
   output logic breaker_open,
   output logic manual_close_req,
   output logic reclose_req,
   output logic [15:0] bus_mag,
   output logic [15:0] line_mag,
   output logic [15:0] mag_delta,
   output logic [15:0] phase_delta,
   output logic [15:0] frequency_delta,
   output logic [15:0] line_terminal_cv,
   output logic [15:0] line_freq
);
   initial begin
      group_req_in = 3'h0;
      element_pickup = 8'h00;
      breaker_open = 1'b0;
      manual_close_req = 1'b0;
      reclose_req = 1'b0;
      bus_mag = 16'hf000;
      line_mag = 16'hf000;
      mag_delta = 16'h0000;
      phase_delta = 16'h0000;
      frequency_delta = 16'h0000;
      line_terminal_cv = 16'h0000;
      line_freq = 16'h0000;
   end
   // Breaker reports closed once the close coil is energised
   always @(posedge pclk) begin
      if (close_out === 1'b1) breaker_open <= 1'b0;
   end
endmodule

// File: sgc_top_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module sgc_top_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] rd;
   logic bd, ld, ex;
   int error_cnt = 0, check_count = 0, ev_n = 0, on, off, n, d;
   wire [31:0] prdata;
   wire pready, pslverr, breaker_open, manual_close_req, reclose_req, close_out, event_pulse;
   wire [3:1] group_req_in;
   wire [7:0] element_pickup;
   wire [15:0] bus_mag, line_mag, mag_delta, phase_delta, frequency_delta;
   wire [15:0] line_terminal_cv, line_freq, line_freq_report;
   wire [1:0] active_group, mc_group;
   wire [3:0] group_led;
   wire [4:0] ioc_block, aux_relay;
   wire [34:0] toc_raise;
   sgc_top #(.SEC_CYCLES(10)) dut_u (.*);
   sgc_field fld_u (.*);
   initial begin
      forever #25 pclk = ~pclk;
   end
   always @(posedge pclk) if (event_pulse === 1'b1) ev_n++;
   task cyc(input int k);
      repeat (k) @(posedge pclk);
      @(negedge pclk);
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) error_cnt++;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task sync(input logic [15:0] m, p, f, input logic rc, input logic e);
      @(posedge pclk);
      fld_u.mag_delta <= m;
      fld_u.phase_delta <= p;
      fld_u.frequency_delta <= f;
      if (rc) fld_u.reclose_req <= 1'b1;
      else fld_u.manual_close_req <= 1'b1;
      cyc(3);
      `CHK(close_out, e)
      @(posedge pclk);
      fld_u.reclose_req <= 1'b0;
      fld_u.manual_close_req <= 1'b0;
      cyc(2);
   endtask
   task scan(input int k);
      on = 0;
      off = 0;
      repeat (k) begin
         @(negedge pclk);
         on += (group_led === 4'b0101);
         off += (group_led === 4'b0001);
      end
   endtask
   task wait_end;
      n = 0;
      while (ioc_block !== 5'h00 && n < 5000) begin
         @(negedge pclk);
         n++;
      end
   endtask
   task finish_test;
      $display("checks=%0d errors=%0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #5_000_000;
      error_cnt++;
      finish_test;
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      cyc(1);
      `CHK(active_group, 2'h0)
      apb(1, 12'h000, 32'h0000_0001);
      cyc(3);
      `CHK(active_group, 2'h1)
      @(posedge pclk) fld_u.group_req_in <= 3'b111;
      cyc(3);
      `CHK(active_group, 2'h3)
      @(posedge pclk) fld_u.group_req_in <= 3'b011;
      cyc(3);
      `CHK(active_group, 2'h2)
      @(posedge pclk) fld_u.group_req_in <= 3'b000;
      cyc(3);
      `CHK(active_group, 2'h1)
      `CHK(ev_n, 4)
      apb(1, 12'h000, 32'h0001_0300);
      @(posedge pclk) fld_u.element_pickup <= 8'h01;
      cyc(3);
      @(posedge pclk) fld_u.group_req_in <= 3'b100;
      cyc(4);
      `CHK(active_group, 2'h0)
      @(posedge pclk) fld_u.element_pickup <= 8'h00;
      cyc(4);
      `CHK(active_group, 2'h3)
      @(posedge pclk) fld_u.breaker_open <= 1'b1;
      @(posedge pclk) fld_u.group_req_in <= 3'b000;
      cyc(4);
      `CHK(active_group, 2'h3)
      @(posedge pclk) fld_u.breaker_open <= 1'b0;
      cyc(4);
      `CHK(active_group, 2'h0)
      apb(1, 12'h000, 32'h0000_0020);
      cyc(2);
      scan(400);
      `CHK(on + off, 400)
      `CHK(on > 0 && off > 0, 1'b1)
      apb(1, 12'h000, 32'h0000_0000);
      cyc(2);
      scan(100);
      `CHK(off, 100)
      apb(0, 12'h0fc, 32'h0);
      `CHK(rd, 32'h0000_0000)
      `CHK(pslverr, 1'b0)
      apb(1, 12'h00c, 32'h1010_1000);
      apb(1, 12'h008, 32'h0000_0001);
      sync(16'h0fff, 16'h000f, 16'h000f, 0, 1'b1);
      sync(16'h1000, 16'h000f, 16'h000f, 0, 1'b0);
      sync(16'h0fff, 16'h0010, 16'h000f, 1, 1'b0);
      sync(16'h0fff, 16'h000f, 16'h0010, 0, 1'b0);
      sync(16'h0fff, 16'h000f, 16'h000f, 1, 1'b1);
      apb(1, 12'h010, 32'h8080_2020);
      for (int c = 0; c < 6; c++) begin
         apb(1, 12'h008, {25'h0, c[2:0], 4'h1});
         for (int k = 0; k < 4; k++) begin
            @(posedge pclk);
            fld_u.bus_mag <= k[0] ? 16'hf000 : 16'h1000;
            fld_u.line_mag <= k[1] ? 16'hf000 : 16'h1000;
            bd = !k[0];
            ld = !k[1];
            ex = (c == 1) ? bd & ld : (c == 2) ? !ld & bd : (c == 3) ? ld & !bd :
               (c == 4) ? bd | ld : (c == 5) ? bd ^ ld : 1'b0;
            sync(16'hffff, 16'hffff, 16'hffff, k[0], ex);
         end
      end
      apb(1, 12'h008, 32'h0000_0000);
      sync(16'hffff, 16'hffff, 16'hffff, 0, 1'b1);
      @(posedge pclk) fld_u.line_freq <= 16'h1770;
      @(posedge pclk) fld_u.line_terminal_cv <= 16'h03e7;
      cyc(2);
      `CHK(line_freq_report, 16'h0000)
      @(posedge pclk) fld_u.line_terminal_cv <= 16'h03e8;
      cyc(2);
      `CHK(line_freq_report, 16'h1770)
      apb(1, 12'h01c, 32'h0000_0007);
      apb(1, 12'h018, 32'h008c_a151);
      @(posedge pclk) fld_u.manual_close_req <= 1'b1;
      cyc(3);
      `CHK(ioc_block, 5'h15)
      `CHK(aux_relay, 5'h0a)
      `CHK(mc_group, 2'h2)
      `CHK(toc_raise, 35'h7)
      @(posedge pclk) fld_u.manual_close_req <= 1'b0;
      wait_end;
      d = n;
      `CHK(d > 0 && d < 5000, 1'b1)
      `CHK(toc_raise, 35'h0)
      `CHK(aux_relay, 5'h00)
      @(posedge pclk) fld_u.manual_close_req <= 1'b1;
      @(posedge pclk) fld_u.manual_close_req <= 1'b0;
      cyc(d / 2);
      @(posedge pclk) fld_u.manual_close_req <= 1'b1;
      cyc(3);
      @(posedge pclk) fld_u.manual_close_req <= 1'b0;
      wait_end;
      `CHK(n > d * 3 / 4 && n < 5000, 1'b1)
      finish_test;
   end
endmodule
